// *** verilog/vint_pkg.sv ***
/*
 * Constants for the vectored interrupt unit: register map, field layout,
 * source indices, vector addresses and timing counts.
 * Assumes an 8-bit register port and a 16-bit program counter in the core.
 */
package vint_pkg;
	// ==========================================================
	// Register map (plain port, 4-bit address)
	localparam logic [3:0] ADDR_REQ1   = 4'h0; // Request bits 7..0
	localparam logic [3:0] ADDR_REQ2   = 4'h1; // Request bits 11..8
	localparam logic [3:0] ADDR_CTL1   = 4'h2; // Enable bits 7..0
	localparam logic [3:0] ADDR_CTL2   = 4'h3; // Enable bits 11..8
	localparam logic [3:0] ADDR_POL    = 4'h4; // Edge polarity, 4 pins
	localparam logic [3:0] ADDR_STAT   = 4'h5; // Sticky event status
	localparam logic [3:0] ADDR_MASK   = 4'h6; // Event interrupt mask
	localparam logic [3:0] ADDR_ACTIVE = 4'h7; // Busy and last source

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;

	// ==========================================================
	// Source indices in priority order, 0 is highest after reset
	localparam int N_MASKABLE = 12;
	localparam int N_SOURCES  = 14;
	localparam logic [3:0] SRC_CRT    = 4'h0;
	localparam logic [3:0] SRC_EXT2   = 4'h1;
	localparam logic [3:0] SRC_EXT1   = 4'h2;
	localparam logic [3:0] SRC_TMR4   = 4'h3;
	localparam logic [3:0] SRC_PERIOD = 4'h4;
	localparam logic [3:0] SRC_VSYNC  = 4'h5;
	localparam logic [3:0] SRC_TMR3   = 4'h6;
	localparam logic [3:0] SRC_TMR2   = 4'h7;
	localparam logic [3:0] SRC_TMR1   = 4'h8;
	localparam logic [3:0] SRC_SERIAL = 4'h9;
	localparam logic [3:0] SRC_I2C    = 4'ha;
	localparam logic [3:0] SRC_EXT3   = 4'hb;
	localparam logic [3:0] SRC_BREAK  = 4'hc;
	localparam logic [3:0] SRC_RESET  = 4'hd;

	// ==========================================================
	// Low byte address of each vector, indexed by source
	localparam logic [15:0] VEC_LO [0:N_SOURCES-1] = '{
		16'hfffc, 16'hfffa, 16'hfff8, 16'hfff4, 16'hfff2, 16'hfff0, 16'hffee,
		16'hffec, 16'hffea, 16'hffe8, 16'hffe6, 16'hffe4, 16'hffde, 16'hfffe
	};

	// ==========================================================
	// Status bit positions
	localparam int STAT_ACCEPT = 0; // Any maskable source accepted
	localparam int STAT_BREAK  = 1; // Break instruction served
	localparam int STAT_RESET  = 2; // Reset vector loaded

	// ==========================================================
	// Timing: periodic source, in oscillator periods
	localparam int PERIOD_OSC = 4096;
endpackage : vint_pkg

// *** verilog/vectored_interrupt_unit.sv ***
/*
 * Vectored interrupt unit: request and enable bits, edge detection on the
 * external request pins, a periodic source, priority selection and the
 * acceptance sequence that stacks PC and status and loads the vector.
 * Assumes the core offers an instruction boundary pulse, stalls while
 * busy_o is high, and returns vector bytes one cycle after vec_rd_o.
 * The system clock stands in for the oscillator clock.
 */
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ns

// Function
// R1 - Fourteen sources: four pins, eight internal, break, reset
// R2 - Own vector per source, fixed priority ranking
// R3 - Acceptance pushes PC and status automatically
// R4 - Acceptance sets disable flag, clears request
// R5 - Then load PC from source vector
// R6 - Request and enable bit per maskable source
// R7 - Accept when enabled, requested, flag clear
// R8 - Software clears request bits, cannot set them
// R9 - Software writes enable bits freely
// R10 - Reset non-maskable, always highest priority
// R11 - Break lowest priority, ignores disable flag
// R12 - Pin edge sets request; polarity selects edge
// R13 - Timer overflow raises its request
// R14 - Periodic request every 4096 oscillator periods
// R15 - Highest pending first, only at boundaries
// R16 - Request stays set until accepted or cleared
module vectored_interrupt_unit import vint_pkg::*; #(
	parameter int PERIOD_DIV = PERIOD_OSC  // Periodic source divide ratio
) (
	input  wire logic        sys_clk_i,    // System clock
	input  wire logic        rst_n_i,      // Asynchronous reset, active low
	// Register port
	input  wire logic [3:0]  reg_addr_i,   // Register address
	input  wire logic [7:0]  reg_wdata_i,  // Write data
	input  wire logic        reg_we_i,     // Write strobe
	input  wire logic        reg_re_i,     // Read strobe
	output logic      [7:0]  reg_rdata_o,  // Read data, cycle after strobe
	output logic             irq_o,        // Unmasked status event level
	// Event sources
	input  wire logic [3:0]  ext_pin_i,    // Pins: one, two, three, vsync
	input  wire logic [3:0]  timer_ovf_i,  // Timer 1..4 overflow pulses
	input  wire logic        crt_done_i,   // Display block done pulse
	input  wire logic        serial_done_i, // Serial transfer pulse
	input  wire logic        i2c_event_i,  // Bus interface pulse
	// Core side
	input  wire logic        boundary_i,   // Instruction boundary pulse
	input  wire logic        break_instruction_i, // Break executes
	input  wire logic        iflag_i,      // Global disable flag
	input  wire logic [15:0] pc_i,         // Return address
	input  wire logic [7:0]  ps_i,         // Processor status
	output logic             busy_o,       // Sequence running, core stalls
	output logic             set_iflag_o,  // Pulse: set disable flag
	output logic             stack_push_o, // Pulse: push stack_data_o
	output logic      [7:0]  stack_data_o, // Byte to push
	output logic             vec_rd_o,     // Pulse: read vector byte
	output logic      [15:0] vec_addr_o,   // Vector byte address
	input  wire logic [7:0]  vec_data_i,   // Vector byte, next cycle
	output logic             pc_load_o,    // Pulse: load pc_value_o
	output logic      [15:0] pc_value_o    // New program counter
);

	// ==========================================================
	// Elaboration checks
	if (PERIOD_DIV < 2 || PERIOD_DIV > 65536) begin : g_chk
		$error("PERIOD_DIV out of range");
	end

	// ==========================================================
	// Types and declarations
	typedef enum logic [2:0] {
		ST_IDLE, ST_PUSH_PCH, ST_PUSH_PCL, ST_PUSH_PS,
		ST_VEC_LO, ST_VEC_HI, ST_LOAD
	} seq_e;
	seq_e                  state_reg;     // Acceptance sequencer
	logic [N_MASKABLE-1:0] req_reg;       // Request bits
	logic [N_MASKABLE-1:0] req_next;      // Next request bits
	logic [N_MASKABLE-1:0] ena_reg;       // Enable bits
	logic [3:0]            pol_reg;       // Edge polarity, 1 = falling
	logic [3:0]            pin_prev_reg;  // Pin level one cycle ago
	logic [3:0]            pin_edge;      // Selected edge seen
	logic [15:0]           div_reg;       // Periodic divider
	logic                  period_tick;   // Periodic event
	logic                  reset_pend_reg; // Reset vector owed
	logic                  break_pend_reg; // Break request held
	logic [N_MASKABLE-1:0] req_set;       // Hardware set terms
	logic [N_MASKABLE-1:0] req_clr;       // Software and accept clears
	logic [N_MASKABLE-1:0] eligible;      // Acceptable maskable sources
	logic                  accept;        // Start a sequence
	logic [3:0]            sel_src;       // Winning source
	logic [3:0]            cur_src_reg;   // Source being served
	logic [15:0]           pc_save_reg;   // Captured return address
	logic [7:0]            ps_save_reg;   // Captured status
	logic [7:0]            vec_lo_reg;    // Fetched low vector byte
	logic [7:0]            stat_reg;      // Sticky event status
	logic [7:0]            mask_reg;      // Event mask
	logic [7:0]            stack_data_reg; // Push data flop
	logic [15:0]           pc_value_reg;  // Load value flop
	logic                  pc_load_reg;   // Load pulse flop
	logic [7:0]            rdata_reg;     // Read data flop
	logic                  wr_stat;       // Write to status

	// ==========================================================
	// Helpers
	// Lowest set index wins, which is the highest priority
	function automatic logic [3:0] pick(input logic [N_MASKABLE-1:0] v);
		logic [3:0] r = 4'h0;
		for (int i = N_MASKABLE - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction : pick
	// Byte of a bit vector, padded with zeros above
	function automatic logic [7:0] byte_of(input logic [N_MASKABLE-1:0] v, input logic hi);
		logic [15:0] w;
		w = 16'(v);
		return hi ? w[15:8] : w[7:0];
	endfunction : byte_of

	// ==========================================================
	// External pin edge detection
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_prev_reg <= 4'h0;
		end else begin
			pin_prev_reg <= ext_pin_i;
		end
	end
	// Rising edge when polarity 0, falling when 1
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_edge[i] = pol_reg[i] ? (pin_prev_reg[i] & ~ext_pin_i[i]) : (~pin_prev_reg[i] & ext_pin_i[i]); // R12
		end
	end

	// ==========================================================
	// Periodic divider
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_reg <= 16'h0000;
		end else if (period_tick) begin
			div_reg <= 16'h0000;
		end else begin
			div_reg <= div_reg + 16'h0001;
		end
	end
	assign period_tick = (div_reg == 16'(PERIOD_DIV - 1)); // R14

	// ==========================================================
	// Request set and clear terms
	always_comb begin
		req_set             = '0; // R1
		req_set[SRC_CRT]    = crt_done_i;
		req_set[SRC_EXT1]   = pin_edge[0]; // R12
		req_set[SRC_EXT2]   = pin_edge[1]; // R12
		req_set[SRC_EXT3]   = pin_edge[2]; // R12
		req_set[SRC_VSYNC]  = pin_edge[3]; // R12
		req_set[SRC_TMR1]   = timer_ovf_i[0]; // R13
		req_set[SRC_TMR2]   = timer_ovf_i[1]; // R13
		req_set[SRC_TMR3]   = timer_ovf_i[2]; // R13
		req_set[SRC_TMR4]   = timer_ovf_i[3]; // R13
		req_set[SRC_PERIOD] = period_tick; // R14
		req_set[SRC_SERIAL] = serial_done_i;
		req_set[SRC_I2C]    = i2c_event_i;
		req_clr = '0;
		// Writing 0 clears, writing 1 leaves the bit alone
		if (reg_we_i && reg_addr_i == ADDR_REQ1) begin
			req_clr[7:0] = ~reg_wdata_i; // R8
		end
		if (reg_we_i && reg_addr_i == ADDR_REQ2) begin
			req_clr[N_MASKABLE-1:8] = ~reg_wdata_i[N_MASKABLE-9:0]; // R8
		end
		// Accepted source loses its request
		if (accept && sel_src < SRC_BREAK) begin
			req_clr[sel_src] = 1'b1; // R4
		end
		// New event wins over any clear in the same cycle
		req_next = (req_reg & ~req_clr) | req_set; // R16
	end

	// Request bits
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_reg <= '0;
		end else begin
			req_reg <= req_next; // R6 R16
		end
	end

	// ==========================================================
	// Enable bits and polarity
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ena_reg <= '0;
			pol_reg <= 4'h0; // R12
		end else if (reg_we_i) begin
			unique case (reg_addr_i)
				ADDR_CTL1: ena_reg[7:0] <= reg_wdata_i; // R9
				ADDR_CTL2: ena_reg[N_MASKABLE-1:8] <= reg_wdata_i[N_MASKABLE-9:0]; // R9
				ADDR_POL:  pol_reg <= reg_wdata_i[3:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Pending reset and break
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reset_pend_reg <= 1'b1; // R10
			break_pend_reg <= 1'b0;
		end else begin
			if (accept && sel_src == SRC_RESET) begin
				reset_pend_reg <= 1'b0;
			end
			if (break_instruction_i) begin
				break_pend_reg <= 1'b1;
			end else if (accept && sel_src == SRC_BREAK) begin
				break_pend_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Priority selection
	assign eligible = iflag_i ? '0 : (req_reg & ena_reg); // R7
	assign accept = (state_reg == ST_IDLE) && !pc_load_reg && boundary_i
		&& (reset_pend_reg || (|eligible) || break_pend_reg); // R15
	always_comb begin
		if (reset_pend_reg) begin
			sel_src = SRC_RESET; // R10
		end else if (|eligible) begin
			sel_src = pick(eligible); // R2 R15
		end else begin
			sel_src = SRC_BREAK; // R11
		end
	end

	// ==========================================================
	// Acceptance sequencer
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (accept) begin
						state_reg <= (sel_src == SRC_RESET) ? ST_VEC_LO : ST_PUSH_PCH; // Reset skips pushes
					end
				end
				ST_PUSH_PCH: state_reg <= ST_PUSH_PCL; // R3
				ST_PUSH_PCL: state_reg <= ST_PUSH_PS; // R3
				ST_PUSH_PS:  state_reg <= ST_VEC_LO; // R3
				ST_VEC_LO:   state_reg <= ST_VEC_HI; // R5
				ST_VEC_HI:   state_reg <= ST_LOAD; // R5
				ST_LOAD:     state_reg <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Captured context and source
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cur_src_reg <= 4'h0;
			pc_save_reg <= 16'h0000;
			ps_save_reg <= 8'h00;
		end else if (accept) begin
			cur_src_reg <= sel_src;
			pc_save_reg <= pc_i;
			ps_save_reg <= ps_i;
		end
	end

	// ==========================================================
	// Stack data flop, loaded for each push cycle
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stack_data_reg <= 8'h00;
		end else if (accept) begin
			stack_data_reg <= pc_i[15:8]; // R3
		end else if (state_reg == ST_PUSH_PCH) begin
			stack_data_reg <= pc_save_reg[7:0]; // R3
		end else if (state_reg == ST_PUSH_PCL) begin
			stack_data_reg <= ps_save_reg; // R3
		end
	end

	// ==========================================================
	// Vector fetch and program counter load
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vec_lo_reg   <= 8'h00;
			pc_value_reg <= 16'h0000;
			pc_load_reg  <= 1'b0;
		end else begin
			pc_load_reg <= (state_reg == ST_LOAD); // R5
			if (state_reg == ST_VEC_HI) begin
				vec_lo_reg <= vec_data_i;
			end
			if (state_reg == ST_LOAD) begin
				pc_value_reg <= {vec_data_i, vec_lo_reg}; // R5
			end
		end
	end

	// ==========================================================
	// Core side outputs
	assign busy_o       = (state_reg != ST_IDLE) || pc_load_reg;
	assign set_iflag_o  = accept; // R4
	assign stack_push_o = (state_reg == ST_PUSH_PCH) || (state_reg == ST_PUSH_PCL)
		|| (state_reg == ST_PUSH_PS); // R3
	assign stack_data_o = stack_data_reg;
	assign vec_rd_o     = (state_reg == ST_VEC_LO) || (state_reg == ST_VEC_HI);
	// Low byte first, then the byte above it
	assign vec_addr_o   = VEC_LO[cur_src_reg] | {15'h0000, state_reg == ST_VEC_HI}; // R2 R5
	assign pc_load_o    = pc_load_reg;
	assign pc_value_o   = pc_value_reg;

	// ==========================================================
	// Event status and mask, write one to clear, set wins
	assign wr_stat = reg_we_i && reg_addr_i == ADDR_STAT;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stat_reg <= RST_BYTE;
			mask_reg <= RST_BYTE;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if ((accept && sel_src < SRC_BREAK && i == STAT_ACCEPT)
					|| (accept && sel_src == SRC_BREAK && i == STAT_BREAK)
					|| (pc_load_reg && cur_src_reg == SRC_RESET && i == STAT_RESET)) begin
					stat_reg[i] <= 1'b1;
				end else if (wr_stat && reg_wdata_i[i]) begin
					stat_reg[i] <= 1'b0;
				end
			end
			if (reg_we_i && reg_addr_i == ADDR_MASK) begin
				mask_reg <= reg_wdata_i;
			end
		end
	end
	assign irq_o = |(stat_reg & mask_reg);

	// ==========================================================
	// Register read, data one cycle after the strobe
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_reg <= 8'h00;
		end else if (reg_re_i) begin
			unique case (reg_addr_i)
				ADDR_REQ1:   rdata_reg <= byte_of(req_reg, 1'b0);
				ADDR_REQ2:   rdata_reg <= byte_of(req_reg, 1'b1);
				ADDR_CTL1:   rdata_reg <= byte_of(ena_reg, 1'b0);
				ADDR_CTL2:   rdata_reg <= byte_of(ena_reg, 1'b1);
				ADDR_POL:    rdata_reg <= {4'h0, pol_reg};
				ADDR_STAT:   rdata_reg <= stat_reg;
				ADDR_MASK:   rdata_reg <= mask_reg;
				ADDR_ACTIVE: rdata_reg <= {3'h0, busy_o, cur_src_reg};
				default:     rdata_reg <= 8'h00; // Unmapped reads zero
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end
	assign reg_rdata_o = rdata_reg;
endmodule : vectored_interrupt_unit

// *** dv/vint_core_model.sv ***
/* Core-side model: answers vector byte reads one cycle after vec_rd_i.
   Assumes the unit's vector port; other core signals come from the bench. */
`timescale 1ns/1ns
module vint_core_model (
	input  wire logic        sys_clk_i,  // System clock
	input  wire logic        rst_n_i,    // Reset, active low
	input  wire logic        vec_rd_i,   // Vector byte read
	input  wire logic [15:0] vec_addr_i, // Vector byte address
	output logic      [7:0]  vec_data_o  // Vector byte
);
	// ==========================================
	// Vector store: each byte derived from its own address
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vec_data_o <= 8'h00;
		end else if (vec_rd_i) begin
			vec_data_o <= vec_addr_i[7:0] ^ 8'h5a;
		end else begin
			vec_data_o <= ~vec_data_o; // Released bus: last byte inverted each cycle, so it returns every second cycle
		end
	end
endmodule : vint_core_model

// *** dv/vectored_interrupt_unit_checker.sv ***
/* Assertions on the acceptance sequence of the interrupt unit.
   Assumes binding onto the unit's top-level ports. */
`timescale 1ns/1ns
module vectored_interrupt_unit_checker #(
	parameter int PERIOD_DIV = 4096 // Periodic divide ratio
) (
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	input wire logic        boundary_i,
	input wire logic        iflag_i,
	input wire logic [15:0] pc_i,
	input wire logic [7:0]  ps_i,
	input wire logic        busy_o,
	input wire logic        set_iflag_o,
	input wire logic        stack_push_o,
	input wire logic [7:0]  stack_data_o,
	input wire logic        vec_rd_o,
	input wire logic [15:0] vec_addr_o,
	input wire logic [7:0]  vec_data_i,
	input wire logic        pc_load_o
	,input wire logic [15:0] pc_value_o
);
	logic [15:0] pc_q; // PC seen at accept
	logic [7:0]  ps_q; // Status seen at accept

	// ==========================================
	// Capture what the core offered at acceptance
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_q <= 16'h0000;
			ps_q <= 8'h00;
		end else if (set_iflag_o) begin
			pc_q <= pc_i;
			ps_q <= ps_i;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	// ==========================================
	// Acceptance sequence
	a_push_then_vector: assert property (set_iflag_o ##1 stack_push_o |-> stack_push_o[*3]
		##1 vec_rd_o[*2] ##1 !pc_load_o ##1 pc_load_o) else $error("accept sequence out of order");
	a_stack_bytes: assert property (set_iflag_o ##1 stack_push_o |-> stack_data_o == pc_q[15:8]
		##1 stack_data_o == pc_q[7:0] ##1 stack_data_o == ps_q) else $error("stacked bytes wrong");
	a_vector_pair: assert property (set_iflag_o ##1 stack_push_o |-> ##3 !vec_addr_o[0]
		##1 vec_addr_o == ($past(vec_addr_o) | 16'h0001)) else $error("vector byte pair wrong");
	a_reset_vector: assert property (set_iflag_o ##1 vec_rd_o |-> vec_addr_o == 16'hfffe
		##1 vec_addr_o == 16'hffff) else $error("reset vector address wrong");
	a_pc_from_vector: assert property (pc_load_o |-> pc_value_o == {$past(vec_data_i),
		$past(vec_data_i, 2)}) else $error("loaded pc not from vector");
	a_busy_window: assert property (set_iflag_o ##1 stack_push_o |-> busy_o[*7] ##1 !busy_o)
		else $error("busy window length wrong");
	a_no_accept_busy: assert property (busy_o |-> !set_iflag_o) else $error("accept while busy");
	a_accept_boundary: assert property (set_iflag_o |-> boundary_i) else $error("accept off boundary");
	a_masked_break: assert property (set_iflag_o && iflag_i ##1 stack_push_o |-> ##3
		vec_addr_o == 16'hffde) else $error("masked accept not break");
endmodule : vectored_interrupt_unit_checker

bind vectored_interrupt_unit vectored_interrupt_unit_checker #(.PERIOD_DIV(PERIOD_DIV)) u_chk (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .boundary_i(boundary_i), .iflag_i(iflag_i),
	.pc_i(pc_i), .ps_i(ps_i), .busy_o(busy_o), .set_iflag_o(set_iflag_o),
	.stack_push_o(stack_push_o), .stack_data_o(stack_data_o), .vec_rd_o(vec_rd_o),
	.vec_addr_o(vec_addr_o), .vec_data_i(vec_data_i), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o));

// *** dv/vectored_interrupt_unit_tb_top.sv ***
/* Self-checking bench for the vectored interrupt unit.
   Assumes the core model answers vector reads; bench plays core and sources. */
`timescale 1ns/1ns
module vectored_interrupt_unit_tb_top;
	import vint_pkg::*;
	logic        sys_clk_i, rst_n_i, reg_we_i, reg_re_i, irq_o, crt_done_i, serial_done_i;
	logic        i2c_event_i, boundary_i, break_instruction_i, iflag_i, busy_o, set_iflag_o;
	logic        stack_push_o, vec_rd_o, pc_load_o;
	logic [3:0]  reg_addr_i, ext_pin_i, timer_ovf_i;
	logic [7:0]  reg_wdata_i, reg_rdata_o, ps_i, stack_data_o, vec_data_i;
	logic [15:0] pc_i, vec_addr_o, pc_value_o;
	int          compares, miscompares;

	vectored_interrupt_unit #(.PERIOD_DIV(8)) u_vectored_interrupt_unit (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
		.reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .ext_pin_i(ext_pin_i), .timer_ovf_i(timer_ovf_i),
		.crt_done_i(crt_done_i), .serial_done_i(serial_done_i), .i2c_event_i(i2c_event_i), .boundary_i(boundary_i),
		.break_instruction_i(break_instruction_i), .iflag_i(iflag_i), .pc_i(pc_i), .ps_i(ps_i), .busy_o(busy_o),
		.set_iflag_o(set_iflag_o), .stack_push_o(stack_push_o), .stack_data_o(stack_data_o), .vec_rd_o(vec_rd_o),
		.vec_addr_o(vec_addr_o), .vec_data_i(vec_data_i), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o));
	vint_core_model u_vint_core_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .vec_rd_i(vec_rd_o),
		.vec_addr_i(vec_addr_o), .vec_data_o(vec_data_i));

	// ==========================================
	// Shared helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_we_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_we_i <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(posedge sys_clk_i);
		reg_re_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_re_i <= 1'b0;
		#1 chk({8'h00, reg_rdata_o & m}, {8'h00, exp});
	endtask : rd
	// Boundary pulse that must be refused
	task automatic none;
		@(posedge sys_clk_i);
		boundary_i <= 1'b1;
		#1 chk({15'h0, set_iflag_o}, 16'h0000);
		@(posedge sys_clk_i);
		boundary_i <= 1'b0;
	endtask : none
	// Boundary pulse that must be accepted, then follow the sequence
	task automatic serve(input logic [15:0] lo, input int np);
		int n;
		logic seen;
		logic [15:0] pcv;
		n = 0;
		seen = 1'b0;
		pcv = 16'h0000;
		@(posedge sys_clk_i);
		boundary_i <= 1'b1;
		#1 chk({15'h0, set_iflag_o}, 16'h0001);
		@(posedge sys_clk_i);
		boundary_i <= 1'b0;
		for (int k = 0; k < 12; k++) begin
			#1;
			if (stack_push_o === 1'b1) n++;
			if (vec_rd_o === 1'b1 && !vec_addr_o[0]) chk(vec_addr_o, lo);
			if (pc_load_o === 1'b1) begin
				seen = 1'b1;
				pcv = pc_value_o;
			end
			@(posedge sys_clk_i);
		end
		chk(16'(n), 16'(np));
		chk({15'h0, seen}, 16'h0001);
		chk(pcv, {lo[7:0] ^ 8'h5b, lo[7:0] ^ 8'h5a});
	endtask : serve

	// ==========================================
	// Scenarios
	task automatic s_reset;
		rd(ADDR_CTL1, 8'hff, RST_BYTE);
		rd(ADDR_POL, 8'hff, RST_BYTE);
		serve(16'hfffe, 0);
	endtask : s_reset
	task automatic s_regs;
		wr(ADDR_REQ1, 8'hff);
		rd(ADDR_REQ1, 8'hef, 8'h00);
		wr(ADDR_CTL1, 8'ha5);
		rd(ADDR_CTL1, 8'hff, 8'ha5);
		wr(ADDR_CTL2, 8'hff);
		rd(ADDR_CTL2, 8'hff, 8'h0f);
	endtask : s_regs
	task automatic s_priority;
		wr(ADDR_CTL1, 8'hef);
		@(posedge sys_clk_i);
		{crt_done_i, serial_done_i, i2c_event_i, timer_ovf_i} <= 7'h7f;
		@(posedge sys_clk_i);
		{crt_done_i, serial_done_i, i2c_event_i, timer_ovf_i} <= 7'h00;
		rd(ADDR_REQ1, 8'hef, 8'hc9);
		rd(ADDR_REQ2, 8'hff, 8'h07);
		serve(16'hfffc, 3);
		rd(ADDR_REQ1, 8'hef, 8'hc8);
		serve(16'hfff4, 3);
		serve(16'hffee, 3);
		wr(ADDR_REQ1, 8'h00);
		wr(ADDR_REQ2, 8'h00);
		rd(ADDR_REQ1, 8'hef, 8'h00);
		rd(ADDR_REQ2, 8'hff, 8'h00);
	endtask : s_priority
	task automatic s_mask;
		@(posedge sys_clk_i);
		iflag_i <= 1'b1;
		@(posedge sys_clk_i);
		timer_ovf_i <= 4'h1;
		@(posedge sys_clk_i);
		timer_ovf_i <= 4'h0;
		none();
		break_instruction_i <= 1'b1;
		@(posedge sys_clk_i);
		break_instruction_i <= 1'b0;
		serve(16'hffde, 3);
		iflag_i <= 1'b0;
		wr(ADDR_CTL2, 8'h0e);
		none();
		wr(ADDR_REQ2, 8'h0e);
		rd(ADDR_REQ2, 8'hff, 8'h00);
	endtask : s_mask
	task automatic s_pins;
		@(posedge sys_clk_i);
		ext_pin_i <= 4'h1;
		repeat (3) @(posedge sys_clk_i);
		rd(ADDR_REQ1, 8'hef, 8'h04);
		wr(ADDR_REQ1, 8'h00);
		@(posedge sys_clk_i);
		ext_pin_i <= 4'h0;
		repeat (3) @(posedge sys_clk_i);
		rd(ADDR_REQ1, 8'hef, 8'h00);
		wr(ADDR_POL, 8'h02);
		@(posedge sys_clk_i);
		ext_pin_i <= 4'h2;
		repeat (3) @(posedge sys_clk_i);
		wr(ADDR_REQ1, 8'h00);
		@(posedge sys_clk_i);
		ext_pin_i <= 4'h0;
		repeat (3) @(posedge sys_clk_i);
		rd(ADDR_REQ1, 8'hef, 8'h02);
		wr(ADDR_REQ1, 8'h00);
	endtask : s_pins
	task automatic s_periodic;
		wr(ADDR_CTL1, 8'h10);
		repeat (10) @(posedge sys_clk_i);
		serve(16'hfff2, 3);
		wr(ADDR_CTL1, 8'h00);
	endtask : s_periodic
	task automatic s_irq;
		chk({15'h0, irq_o}, 16'h0000);
		wr(ADDR_MASK, 8'h02);
		chk({15'h0, irq_o}, 16'h0001);
		wr(ADDR_STAT, 8'h02);
		chk({15'h0, irq_o}, 16'h0000);
		rd(ADDR_STAT, 8'hff, 8'h05);
		rd(ADDR_ACTIVE, 8'hff, {4'h0, SRC_PERIOD});
		rd(4'hf, 8'hff, 8'h00);
	endtask : s_irq

	task final_report;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	// ==========================================
	// Clock, watchdog and main sequence
	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		repeat (5000) @(posedge sys_clk_i);
		miscompares++;
		final_report();
	end
	initial begin
		{rst_n_i, reg_we_i, reg_re_i, crt_done_i, serial_done_i, i2c_event_i} = 6'h00;
		{boundary_i, break_instruction_i, iflag_i, reg_addr_i, ext_pin_i, timer_ovf_i} = 15'h0000;
		reg_wdata_i = 8'h00;
		pc_i = 16'h1234;
		ps_i = 8'ha5;
		compares = 0;
		miscompares = 0;
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		s_reset();
		s_regs();
		s_priority();
		s_mask();
		s_pins();
		s_periodic();
		s_irq();
		final_report();
	end
endmodule : vectored_interrupt_unit_tb_top
